// ---- lem_link_monitor.sv ----
`timescale 1ns/1ps
module lem_link_monitor
  import lem_pkg::*;
#(
  parameter int unsigned REV_HOLD_CYCLES    = REV_HOLD_CYC,
  parameter int unsigned GPI_LATENCY_CYCLES = GPI_LAT_CYC
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  input  wire logic             power_down_n,
  input  wire logic             config_write_lock,
  input  wire logic             serial_link_enable,
  input  wire logic             video_lock_detect,
  input  wire logic             symbol_strobe,
  input  wire logic             code_error,
  input  wire logic             det_error_pulse,
  input  wire logic             corr_error_pulse,
  input  wire logic [CNT_W-1:0] det_threshold,
  input  wire logic [CNT_W-1:0] corr_threshold,
  input  wire logic             prbs_test_active,
  input  wire logic             prbs_error_pulse,
  output logic      [CNT_W-1:0] prbs_error_count,
  output logic                  video_lock,
  output logic                  relock_request,
  output logic                  forward_channel_active,
  output logic                  reverse_channel_active,
  output logic      [7:0]       serializer_address,
  output logic      [7:0]       deserializer_address,
  output logic                  stagger_enable,
  input  wire logic             remote_input_pin,
  output logic                  remote_output_pin,
  output logic                  err_flag_o,
  output logic                  err_flag_oe_n,
  input  wire logic             pin0_i,
  output logic                  pin0_o,
  output logic                  pin0_oe_n,
  input  wire logic             pin1_i,
  output logic                  pin1_o,
  output logic                  pin1_oe_n
);
  typedef struct packed {
    logic [7:0]        ser_addr;
    logic [7:0]        des_addr;
    logic [1:0]        cc_en;
    logic              auto_clr_en;
    logic              stag_dis;
    logic              pin1_out;
    logic              pin0_out;
    logic              cfg_locked;
    logic [7:0]        rdata;
    lem_lock_st_t      lock_st;
    logic [WIN_W-1:0]  win_cnt;
    logic [WERR_W-1:0] win_err;
    logic              flag_low;
    logic [ATMR_W-1:0] auto_tmr;
    logic              link_en_d;
    logic [TMR_W-1:0]  rev_tmr;
    logic              gpi_last;
    logic              gpi_out;
    logic [TMR_W-1:0]  gpi_tmr;
    logic [CNT_W-1:0]  prbs_cnt;
  } lem_core_state_t;

  localparam lem_core_state_t ST_RST = '{
    ser_addr:    RST_SER_ADDR,
    des_addr:    RST_DES_ADDR,
    cc_en:       RST_CC_EN,
    auto_clr_en: RST_AUTO_CLR,
    stag_dis:    RST_STAG_DIS,
    pin1_out:    RST_PIN_OUT,
    pin0_out:    RST_PIN_OUT,
    cfg_locked:  1'b0,
    rdata:       8'h00,
    lock_st:     LEM_UNLOCKED,
    win_cnt:     '0,
    win_err:     '0,
    flag_low:    1'b0,
    auto_tmr:    '0,
    link_en_d:   1'b0,
    rev_tmr:     '0,
    gpi_last:    1'b0,
    gpi_out:     1'b0,
    gpi_tmr:     '0,
    prbs_cnt:    '0
  };

  localparam int AUTO_BOUND = 60;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  lem_core_state_t  r;
  lem_core_state_t  n;
  logic [3:0]       pins_sync;
  logic             pd_n_sync;
  logic             gpi_sync;
  logic             pin0_sync;
  logic             pin1_sync;
  logic [CNT_W-1:0] det_count;
  logic [CNT_W-1:0] corr_count;
  logic             det_over;
  logic             corr_over;
  logic             count_en;
  logic             lock_event;
  logic             auto_run;
  logic             auto_fire;
  logic             rate_trip;
  logic             clr_det;
  logic             clr_corr;
  logic             wr_ok;
  logic [WERR_W-1:0] win_total;
  logic [1:0][CNT_W-1:0] cnt_val;
  logic [1:0]            cnt_over;

  lem_sync2 #(
    .W (4)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({power_down_n, remote_input_pin, pin1_i, pin0_i}),
    .q     (pins_sync)
  );

  assign pd_n_sync = pins_sync[3];
  assign gpi_sync  = pins_sync[2];
  assign pin1_sync = pins_sync[1];
  assign pin0_sync = pins_sync[0];

  // Counting stops whenever the video link is not locked.
  assign count_en   = (r.lock_st == LEM_LOCKED);
  assign lock_event = (r.lock_st == LEM_UNLOCKED) && video_lock_detect &&
                      serial_link_enable;
  assign auto_run   = r.auto_clr_en && !prbs_test_active && r.flag_low;
  assign auto_fire  = auto_run &&
                      (r.auto_tmr == ATMR_W'(AUTO_CLR_CYC - 1));
  assign win_total  = WERR_W'(r.win_err + {{(WERR_W-1){1'b0}}, code_error});
  assign rate_trip  = count_en && symbol_strobe &&
                      (r.win_cnt == WIN_W'(RATE_WINDOW - 1)) &&
                      (win_total >= WERR_W'(RATE_TRIP));
  assign clr_det    = lock_event || auto_fire ||
                      (reg_rd && hit(reg_addr, OFS_DET_CNT));
  assign clr_corr   = lock_event || auto_fire ||
                      (reg_rd && hit(reg_addr, OFS_CORR_CNT));
  assign wr_ok      = reg_wr && !r.cfg_locked;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cnt
      lem_err_counter u_cnt (
        .clk       (clk),
        .reset     (reset),
        .count_en  (count_en),
        .inc       (gi == 0 ? det_error_pulse : corr_error_pulse),
        .clear     (gi == 0 ? clr_det : clr_corr),
        .hold_zero (prbs_test_active),
        .threshold (gi == 0 ? det_threshold : corr_threshold),
        .count     (cnt_val[gi]),
        .over      (cnt_over[gi])
      );
    end
  endgenerate

  assign det_count  = cnt_val[0];
  assign corr_count = cnt_val[1];
  assign det_over   = cnt_over[0];
  assign corr_over  = cnt_over[1];

  always_comb begin
    n = r;
    // Video lock tracking and the error-rate trip.
    case (r.lock_st)
      LEM_UNLOCKED: begin
        n.win_cnt = '0;
        n.win_err = '0;
        if (lock_event) begin
          n.lock_st = LEM_LOCKED;
        end
      end
      LEM_LOCKED: begin
        if (!video_lock_detect || !serial_link_enable) begin
          n.lock_st = LEM_UNLOCKED;
        end else if (rate_trip) begin
          n.lock_st = LEM_RELOCK;
          n.win_cnt = '0;
          n.win_err = '0;
        end else if (symbol_strobe) begin
          n.win_cnt = WIN_W'(r.win_cnt + 1'b1);
          n.win_err = (r.win_cnt == WIN_W'(RATE_WINDOW - 1)) ? '0 : win_total;
        end
      end
      LEM_RELOCK: begin
        n.lock_st = LEM_UNLOCKED;
      end
      default: begin
        n.lock_st = LEM_UNLOCKED;
      end
    endcase

    // Test-mode error counter kept apart from the link counters.
    if (!prbs_test_active) begin
      n.prbs_cnt = '0;
    end else if (prbs_error_pulse && (r.prbs_cnt != '1)) begin
      n.prbs_cnt = CNT_W'(r.prbs_cnt + 1'b1);
    end

    // Flag is low over threshold, or on any test error in test mode.
    n.flag_low = prbs_test_active ? (r.prbs_cnt != '0)
                                  : (det_over || corr_over);

    // Automatic clear timer runs while the flag is low, when enabled and outside test mode.
    if (auto_run && !auto_fire) begin
      n.auto_tmr = ATMR_W'(r.auto_tmr + 1'b1);
    end else begin
      n.auto_tmr = '0;
    end

    // Reverse channel hold-off after any link start or stop.
    n.link_en_d = serial_link_enable;
    if (serial_link_enable != r.link_en_d) begin
      n.rev_tmr = TMR_W'(REV_HOLD_CYCLES);
    end else if (r.rev_tmr != '0) begin
      n.rev_tmr = TMR_W'(r.rev_tmr - 1'b1);
    end

    // Local input level is forwarded after a fixed latency.
    if (gpi_sync != r.gpi_last) begin
      n.gpi_last = gpi_sync;
      n.gpi_tmr  = TMR_W'(GPI_LATENCY_CYCLES);
    end else if (r.gpi_tmr != '0) begin
      n.gpi_tmr = TMR_W'(r.gpi_tmr - 1'b1);
      if (r.gpi_tmr == TMR_W'(1)) begin
        n.gpi_out = r.gpi_last;
      end
    end

    // Register reads return the value before any clear-on-read.
    if (reg_rd) begin
      case (reg_addr)
        OFS_SER_ADDR: n.rdata = r.ser_addr;
        OFS_DES_ADDR: n.rdata = r.des_addr;
        OFS_CC_EN:    n.rdata = {6'h00, r.cc_en};
        OFS_ERR_CTRL: n.rdata = {4'h0, r.stag_dis, r.auto_clr_en, 2'h0};
        OFS_GPIO:     n.rdata = {4'h0, r.pin1_out, pin1_sync,
                                 r.pin0_out, pin0_sync};
        OFS_DET_CNT:  n.rdata = det_count;
        OFS_CORR_CNT: n.rdata = corr_count;
        default:      n.rdata = 8'h00;
      endcase
    end

    // Writes are dropped once configuration is locked.
    if (wr_ok) begin
      case (reg_addr)
        OFS_SER_ADDR: n.ser_addr = reg_wdata;
        OFS_DES_ADDR: n.des_addr = reg_wdata;
        OFS_CC_EN:    n.cc_en    = reg_wdata[1:0];
        OFS_ERR_CTRL: begin
          n.auto_clr_en = reg_wdata[BIT_AUTO_CLR];
          n.stag_dis    = reg_wdata[BIT_STAG_DIS];
        end
        OFS_GPIO: begin
          n.pin1_out = reg_wdata[BIT_PIN1_OUT];
          n.pin0_out = reg_wdata[BIT_PIN0_OUT];
        end
        default: begin
        end
      endcase
    end

    if (config_write_lock) begin
      n.cfg_locked = 1'b1;
    end

    // Power-down restores every setting and releases the lock.
    if (!pd_n_sync) begin
      n = ST_RST;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata              = r.rdata;
  assign prbs_error_count       = r.prbs_cnt;
  assign video_lock             = (r.lock_st == LEM_LOCKED);
  assign relock_request         = (r.lock_st == LEM_RELOCK);
  assign forward_channel_active = r.cc_en[BIT_FWD_EN];
  // Reverse traffic does not depend on forward link or video lock.
  assign reverse_channel_active = r.cc_en[BIT_REV_EN] &&
                                  (r.rev_tmr == '0);
  assign serializer_address     = r.ser_addr;
  assign deserializer_address   = r.des_addr;
  assign stagger_enable         = !r.stag_dis;
  assign remote_output_pin      = r.gpi_out;
  assign err_flag_o             = 1'b0;
  assign err_flag_oe_n          = !r.flag_low;
  assign pin0_o                 = 1'b0;
  assign pin0_oe_n              = r.pin0_out;
  assign pin1_o                 = 1'b0;
  assign pin1_oe_n              = r.pin1_out;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_lock_clears;
    (lock_event && !det_error_pulse && !corr_error_pulse) |=>
      (det_count == '0 && corr_count == '0);
  endproperty
  a_lock_clears: assert property (p_lock_clears)
    else $error("Counters not cleared by video lock.");

  property p_prbs_hold;
    prbs_test_active |=> (det_count == '0 && corr_count == '0);
  endproperty
  a_prbs_hold: assert property (p_prbs_hold)
    else $error("Link counters not held at zero in test mode.");

  property p_flag_low;
    (pd_n_sync && !prbs_test_active && (det_count > det_threshold)) |=>
      !err_flag_oe_n;
  endproperty
  a_flag_low: assert property (p_flag_low)
    else $error("Error flag not pulled low over threshold.");

  property p_flag_release;
    (!prbs_test_active && det_count == '0 && corr_count == '0) |=>
      err_flag_oe_n;
  endproperty
  a_flag_release: assert property (p_flag_release)
    else $error("Error flag stays low with empty counters.");

  sequence s_flag_fall;
    $rose(r.flag_low) && r.auto_clr_en && !prbs_test_active;
  endsequence

  property p_auto_clear;
    s_flag_fall |-> ##[1:AUTO_BOUND]
      (auto_fire || !r.flag_low || prbs_test_active || !r.auto_clr_en);
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("Automatic clear did not act in time.");

  property p_auto_not_early;
    s_flag_fall |-> !auto_fire [*8];
  endproperty
  a_auto_not_early: assert property (p_auto_not_early)
    else $error("Automatic clear fired too early.");

  property p_auto_off_prbs;
    prbs_test_active |-> !auto_fire;
  endproperty
  a_auto_off_prbs: assert property (p_auto_off_prbs)
    else $error("Automatic clear ran in test mode.");

  sequence s_drop;
    relock_request ##1 (!video_lock && !relock_request);
  endsequence

  property p_rate_drop;
    rate_trip && pd_n_sync |=> s_drop;
  endproperty
  a_rate_drop: assert property (p_rate_drop)
    else $error("Lock not dropped on high error rate.");

  property p_rev_hold;
    $changed(serial_link_enable) |=> !reverse_channel_active [*8];
  endproperty
  a_rev_hold: assert property (p_rev_hold)
    else $error("Reverse channel available during hold-off.");

  property p_cfg_block;
    (r.cfg_locked && reg_wr && pd_n_sync) |=>
      ($stable(serializer_address) && $stable(forward_channel_active));
  endproperty
  a_cfg_block: assert property (p_cfg_block)
    else $error("Register changed while configuration locked.");
endmodule : lem_link_monitor

// ---- lem_pkg.sv ----
package lem_pkg;
// Overview of operation
// - Keep 8-bit detected (0x10) and corrected (0x12) error counters, readable.
// - Error rate of one in four drops lock, freezes counting, retries lock.
// - Counters clear on video lock, own register read, or automatic clear.
// - In pseudo-random test, count test errors apart, hold link counters zero.
// - Error flag pulls low over threshold, or on any test error in test.
// - Error flag returns high once both counters are at or below threshold, outside test mode.
// - Automatic clear empties counters and releases flag about 1 us later.
// - Automatic clear is off at power-up, enabled by bit D2 of 0x08.
// - Automatic clear never runs during pseudo-random test mode.
// - Bits D[1:0] of 0x04 gate forward and reverse control channels.
// - Reverse control channel unavailable for 350 us after link start or stop.
// - Lock output means video lock only; reverse channel needs no lock.
// - Local input reaches remote output after about 275 us, skew under 115 us.
// - Serializer address lives at 0x00, deserializer address at 0x01.
// - Once config lock is set, registers are read-only until power-down.
// - Bits D3 and D1 of 0x0E drive two open-drain pins; 0 pulls low.
// - Pin inputs always sampled into D2 and D0; set output 1 to use input.
// - Output staggering is on by default, off by bit D3 of 0x08.
// - Staggering spreads output groups and pixel clock; disabled means none.

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned TMR_W         = 16;
  localparam int unsigned ATMR_W        = 8;

  localparam logic [7:0] OFS_SER_ADDR  = 8'h00;
  localparam logic [7:0] OFS_DES_ADDR  = 8'h01;
  localparam logic [7:0] OFS_CC_EN     = 8'h04;
  localparam logic [7:0] OFS_ERR_CTRL  = 8'h08;
  localparam logic [7:0] OFS_GPIO      = 8'h0e;
  localparam logic [7:0] OFS_DET_CNT   = 8'h10;
  localparam logic [7:0] OFS_CORR_CNT  = 8'h12;

  localparam int unsigned BIT_FWD_EN   = 0;
  localparam int unsigned BIT_REV_EN   = 1;
  localparam int unsigned BIT_AUTO_CLR = 2;
  localparam int unsigned BIT_STAG_DIS = 3;
  localparam int unsigned BIT_PIN0_IN  = 0;
  localparam int unsigned BIT_PIN0_OUT = 1;
  localparam int unsigned BIT_PIN1_IN  = 2;
  localparam int unsigned BIT_PIN1_OUT = 3;

  // Address values are arbitrary neutral defaults.
  localparam logic [7:0] RST_SER_ADDR  = 8'h80;
  localparam logic [7:0] RST_DES_ADDR  = 8'h90;
  localparam logic [1:0] RST_CC_EN     = 2'h3;
  localparam logic       RST_AUTO_CLR  = 1'b0;
  localparam logic       RST_STAG_DIS  = 1'b0;
  localparam logic       RST_PIN_OUT   = 1'b1;

  localparam int unsigned AUTO_CLR_NS  = 1000;
  localparam int unsigned AUTO_CLR_CYC =
    (AUTO_CLR_NS / CLK_PERIOD_NS < 1) ? 1 : AUTO_CLR_NS / CLK_PERIOD_NS;
  localparam int unsigned REV_HOLD_US  = 350;
  localparam int unsigned REV_HOLD_CYC =
    (REV_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GPI_LAT_US   = 275;
  localparam int unsigned GPI_LAT_CYC  =
    (GPI_LAT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned RATE_WINDOW  = 16;
  localparam int unsigned RATE_TRIP    = 4;
  localparam int unsigned WIN_W        = 4;
  localparam int unsigned WERR_W       = 5;

  typedef enum logic [1:0] {
    LEM_UNLOCKED,
    LEM_LOCKED,
    LEM_RELOCK
  } lem_lock_st_t;
endpackage : lem_pkg

// ---- lem_sync2.sv ----
`timescale 1ns/1ps
module lem_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lem_sync_state_t;

  lem_sync_state_t r;
  lem_sync_state_t n;

  always_comb begin
    n    = r;
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.s2;
endmodule : lem_sync2

// ---- lem_err_counter.sv ----
`timescale 1ns/1ps
module lem_err_counter
  import lem_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             count_en,
  input  wire logic             inc,
  input  wire logic             clear,
  input  wire logic             hold_zero,
  input  wire logic [CNT_W-1:0] threshold,
  output logic      [CNT_W-1:0] count,
  output logic                  over
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } lem_cnt_state_t;

  lem_cnt_state_t r;
  lem_cnt_state_t n;
  logic           bump;

  always_comb begin
    n    = r;
    bump = count_en && inc;
    if (hold_zero) begin
      n.cnt = '0;
    end else if (clear) begin
      n.cnt = bump ? CNT_W'(1) : '0;
    end else if (bump && (r.cnt != '1)) begin
      n.cnt = CNT_W'(r.cnt + 1'b1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign count = r.cnt;
  assign over  = r.cnt > threshold;

  property p_clear_empties;
    @(posedge clk) disable iff (reset)
      (clear && !bump) |=> (count == '0);
  endproperty
  a_clear_empties: assert property (p_clear_empties)
    else $error("Counter not empty after clear.");

  property p_saturates;
    @(posedge clk) disable iff (reset)
      (count == '1 && !clear && !hold_zero) |=> (count == '1);
  endproperty
  a_saturates: assert property (p_saturates)
    else $error("Counter wrapped past its maximum.");
endmodule : lem_err_counter

// ---- lem_far_end.sv ----
`timescale 1ns/1ps
module lem_far_end (
  input  wire logic clk,
  input  wire logic serial_link_enable,
  output logic      video_lock_detect,
  output logic      symbol_strobe,
  output logic      code_error,
  output logic      det_error_pulse,
  output logic      corr_error_pulse,
  output logic      prbs_error_pulse
);
  logic [3:0] lock_dly = 4'h0;

  // Lock is regained a few cycles after the link is enabled.
  always @(posedge clk) begin
    lock_dly <= {lock_dly[2:0], serial_link_enable};
  end
  assign video_lock_detect = lock_dly[3];

  initial begin
    symbol_strobe = 1'b0;
    code_error = 1'b0;
    det_error_pulse = 1'b0;
    corr_error_pulse = 1'b0;
    prbs_error_pulse = 1'b0;
  end

  // No control-channel traffic is sent, so no bit-rate step is made.
  // Sends n back-to-back events: 0 detected, 1 corrected, 2 test error.
  task automatic events(input int kind, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) #1;
      det_error_pulse = (kind == 0);
      corr_error_pulse = (kind == 1);
      prbs_error_pulse = (kind == 2);
    end
    @(posedge clk) #1;
    det_error_pulse = 1'b0;
    corr_error_pulse = 1'b0;
    prbs_error_pulse = 1'b0;
  endtask : events

  // Sends one window of 16 symbols, the first nerr of them in error.
  task automatic symbols(input int nerr);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk) #1;
      symbol_strobe = 1'b1;
      code_error = (i < nerr);
    end
    @(posedge clk) #1;
    symbol_strobe = 1'b0;
    code_error = 1'b0;
  endtask : symbols
endmodule : lem_far_end

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import lem_pkg::*;
  localparam int HOLD = 20;
  localparam int LAT  = 10;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, power_down_n = 1;
  logic config_write_lock = 0, serial_link_enable = 1, prbs_test_active = 0;
  logic remote_input_pin = 0, ext0 = 1, ext1 = 1, trip_seen = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [CNT_W-1:0] det_threshold = 8'h02, corr_threshold = 8'hff;
  logic [CNT_W-1:0] prbs_error_count;
  logic [7:0] serializer_address, deserializer_address;
  logic video_lock, relock_request, forward_channel_active, stagger_enable;
  logic reverse_channel_active, remote_output_pin, err_flag_o, err_flag_oe_n;
  logic pin0_o, pin0_oe_n, pin1_o, pin1_oe_n, pin0_i, pin1_i;
  logic video_lock_detect, symbol_strobe, code_error;
  logic det_error_pulse, corr_error_pulse, prbs_error_pulse;
  int n_mismatch = 0, check_count = 0;

  assign pin0_i = (pin0_oe_n | pin0_o) & ext0;
  assign pin1_i = (pin1_oe_n | pin1_o) & ext1;
  always #10 clk = ~clk;
  always @(posedge clk) if (relock_request === 1'b1) trip_seen <= 1'b1;

  lem_link_monitor #(.REV_HOLD_CYCLES(HOLD), .GPI_LATENCY_CYCLES(LAT))
    dut (.*);
  lem_far_end far (.*);

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step();
    reg_wr = 1'b0;
    step();
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a,
                    input logic [7:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    step();
    reg_rd = 1'b0;
    chk(what, exp, reg_rdata);
    step();
  endtask : rd
  task automatic flag(input logic exp);
    chk("err_flag", {7'h0, exp}, {6'h0, err_flag_o, err_flag_oe_n});
  endtask : flag
  task automatic done(input string name);
    $display("finished %s", name);
  endtask : done
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  initial begin
    #(20 * 5000);
    n_mismatch++;
    $display("unexpected watchdog: expected end seen hang");
    results();
  end

  initial begin
    repeat (12) @(posedge clk);
    #1 reset = 0;
    step(3);
    rd("ser", OFS_SER_ADDR, 8'h80);
    rd("des", OFS_DES_ADDR, 8'h90);
    rd("ctrl", OFS_ERR_CTRL, 8'h00);
    rd("gpio", OFS_GPIO, 8'h0f);
    chk("lock", 8'h01, {7'h0, video_lock});
    chk("stag", 8'h01, {7'h0, stagger_enable});
    chk("des out", 8'h90, deserializer_address);
    done("reset");
    far.events(0, 2);
    step(3);
    flag(1'b1);
    far.events(0, 1);
    step(3);
    flag(1'b0);
    rd("det", OFS_DET_CNT, 8'h03);
    rd("det", OFS_DET_CNT, 8'h00);
    step(3);
    flag(1'b1);
    far.events(1, 260);
    step(3);
    flag(1'b1);
    rd("corr", OFS_CORR_CNT, 8'hff);
    rd("corr", OFS_CORR_CNT, 8'h00);
    rd("unmapped", 8'h13, 8'h00);
    corr_threshold = 8'h00;
    far.events(1, 1);
    step(3);
    flag(1'b0);
    rd("corr", OFS_CORR_CNT, 8'h01);
    step(3);
    flag(1'b1);
    corr_threshold = 8'hff;
    done("counters");
    wr(OFS_ERR_CTRL, 8'h04);
    far.events(0, 3);
    step(40);
    flag(1'b0);
    step(15);
    flag(1'b1);
    rd("det", OFS_DET_CNT, 8'h00);
    done("auto clear");
    prbs_test_active = 1'b1;
    far.events(0, 3);
    rd("det", OFS_DET_CNT, 8'h00);
    far.events(2, 1);
    step(60);
    flag(1'b0);
    chk("prbs", 8'h01, prbs_error_count);
    prbs_test_active = 1'b0;
    wr(OFS_ERR_CTRL, 8'h08);
    chk("stag", 8'h00, {7'h0, stagger_enable});
    done("test mode");
    far.symbols(3);
    step(2);
    chk("trip", 8'h00, {7'h0, trip_seen});
    far.symbols(4);
    step(2);
    chk("trip", 8'h01, {7'h0, trip_seen});
    step(8);
    chk("lock", 8'h01, {7'h0, video_lock});
    done("lock");
    wr(OFS_CC_EN, 8'h00);
    chk("cc", 8'h00, {6'h0, reverse_channel_active,
                      forward_channel_active});
    wr(OFS_CC_EN, 8'h03);
    serial_link_enable = 1'b0;
    step(2);
    chk("cc", 8'h01, {6'h0, reverse_channel_active,
                      forward_channel_active});
    serial_link_enable = 1'b1;
    step(HOLD + 4);
    chk("cc", 8'h03, {6'h0, reverse_channel_active,
                      forward_channel_active});
    done("channels");
    wr(OFS_GPIO, 8'h0d);
    chk("pins", 8'h04, {4'h0, pin1_o, pin1_oe_n, pin0_o, pin0_oe_n});
    step(3);
    rd("gpio", OFS_GPIO, 8'h0c);
    wr(OFS_GPIO, 8'h0f);
    ext1 = 1'b0;
    step(3);
    rd("gpio", OFS_GPIO, 8'h0b);
    remote_input_pin = 1'b1;
    step(LAT);
    chk("gpo", 8'h00, {7'h0, remote_output_pin});
    step(8);
    chk("gpo", 8'h01, {7'h0, remote_output_pin});
    done("pins");
    wr(OFS_SER_ADDR, 8'h42);
    chk("ser", 8'h42, serializer_address);
    config_write_lock = 1'b1;
    step();
    config_write_lock = 1'b0;
    wr(OFS_SER_ADDR, 8'h55);
    rd("ser", OFS_SER_ADDR, 8'h42);
    power_down_n = 1'b0;
    step(4);
    power_down_n = 1'b1;
    step(4);
    rd("ser", OFS_SER_ADDR, 8'h80);
    wr(OFS_SER_ADDR, 8'h55);
    rd("ser", OFS_SER_ADDR, 8'h55);
    done("lock out");
    results();
  end
endmodule : tb
